//--- pbs_pkg.sv
// package of constants and types for the pipelined burst sram
package pbs_pkg;
    localparam int ADDR_W    = 18;
    localparam int DATA_W    = 18;
    localparam int LANE_W    = 9;
    localparam int DEPTH     = 262144;
    localparam int BURST_W   = 2;
    localparam logic [1:0] BURST_ZERO = 2'h0;
    localparam logic [1:0] BURST_ONE  = 2'h1;
    localparam logic [17:0] ADDR_RST = 18'h00000;
    localparam logic [17:0] DATA_RST = 18'h00000;

    typedef enum logic [1:0] {
        PBS_IDLE  = 2'b00,
        PBS_READ  = 2'b01,
        PBS_WRITE = 2'b10
    } pbs_cycle_e;
endpackage : pbs_pkg

//--- pbs_burst_if.sv
// burst address carrier between the core and the burst counter
`timescale 1ns/100ps
interface pbs_burst_if;
    import pbs_pkg::*;
    logic                 load;
    logic                 step;
    logic                 interleave;
    logic [BURST_W-1:0]   load_low;
    logic [BURST_W-1:0]   low_addr;
    modport core (output load, output step, output interleave, output load_low,
                  input low_addr);
    modport cnt  (input load, input step, input interleave, input load_low,
                  output low_addr);
endinterface : pbs_burst_if

//--- pbs_burst_cnt.sv
// 2-bit burst address counter, linear or interleaved
`timescale 1ns/100ps
module pbs_burst_cnt
    import pbs_pkg::*;
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   reset_n,
    // burst control
    pbs_burst_if.cnt    bus
);
    typedef struct packed {
        logic [BURST_W-1:0] base;
        logic [BURST_W-1:0] count;
    } pbs_cnt_s;

    pbs_cnt_s st;
    pbs_cnt_s next_st;

    always_comb begin
        next_st = st;
        if (bus.load) begin
            next_st.base  = bus.load_low;
            next_st.count = BURST_ZERO;
        end else if (bus.step) begin
            next_st.count = st.count + BURST_ONE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // strap is static, so switching order mid burst is undefined by design
    assign bus.low_addr = bus.interleave ? (st.base ^ st.count)
                                         : (st.base + st.count);

    a_step_linear: assert property (@(posedge clk) disable iff (!reset_n)
        (bus.step && !bus.load && !bus.interleave && $stable(bus.interleave))
        |=> bus.low_addr == $past(bus.low_addr) + BURST_ONE)
        else $error("linear step wrong");
    a_step_ileave: assert property (@(posedge clk) disable iff (!reset_n)
        (bus.step && !bus.load && bus.interleave && $stable(bus.interleave))
        |=> bus.low_addr == (st.base ^ ($past(st.count) + BURST_ONE)))
        else $error("interleaved step wrong");
    a_load_first: assert property (@(posedge clk) disable iff (!reset_n)
        bus.load |=> bus.low_addr == $past(bus.load_low))
        else $error("burst load wrong");
endmodule : pbs_burst_cnt

//--- pbs_sram.sv
// pipelined burst synchronous sram, 256k x 18, top level
// Functional notes
// - array of 256K words, 18 bits, two lanes
// - 2-bit counter supplies low burst bits
// - inputs registered except output enable, strap; code registers output enable too
// - either strobe starts burst; advance steps it
// - strap low linear, high interleaved
// - write starts at edge, self timed
// - write enable writes only selected lanes
// - global write or all byte writes: both lanes
// - lane a byte write gates lane a only
// - read data registered, output next edge
// - controller strobe aborts burst, loads, starts cycle
// - processor strobe aborts; ignored when enable high
// - main enable low active; deselect via controller
// - depth enables high and low gate selection
// - output enable low drives, high floats
// - global write writes all lanes
// - write enable writes selected lanes only
// - advance steps counter once in current order
`timescale 1ns/100ps
module pbs_sram
    import pbs_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // address and control, sampled on the rising edge
    input  wire logic [ADDR_W-1:0]   address_inputs,
    input  wire logic                controller_addr_strobe_n,
    input  wire logic                processor_addr_strobe_n,
    input  wire logic                burst_advance_n,
    input  wire logic                chip_enable_main_n,
    input  wire logic                depth_enable_high,
    input  wire logic                depth_enable_low_n,
    input  wire logic                global_write_n,
    input  wire logic                write_enable_n,
    input  wire logic [1:0]          byte_write_lanes_n,
    // static and asynchronous controls
    input  wire logic                burst_order_strap,
    input  wire logic                output_enable_n,
    // data lanes, split into in, out and enable
    input  wire logic [DATA_W-1:0]   data_lanes_in,
    output logic      [DATA_W-1:0]   data_lanes_out,
    output logic                     data_lanes_oe
);
    typedef struct packed {
        pbs_cycle_e           cycle;
        logic [ADDR_W-1:0]    addr;
        logic [1:0]           lane_we;
        logic                 read_pend;
        logic [DATA_W-1:0]    read_data;
        logic                 out_valid;
        logic [DATA_W-1:0]    dout;
        logic                 oe;
    } pbs_state_s;

    pbs_state_s st;
    pbs_state_s next_st;

    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] array_word;

    // registered input stage
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] din_q;
    logic [DATA_W-1:0] din_qq;
    logic              controller_addr_strobe_q, processor_addr_strobe_q, adv_q, ce1_q, ce2_q, ce3_q;
    logic              gw_q, we_q;
    logic [1:0]        bw_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_q <= ADDR_RST;
            din_q  <= DATA_RST;
            din_qq <= DATA_RST;
            controller_addr_strobe_q <= 1'b1;
            processor_addr_strobe_q <= 1'b1;
            adv_q  <= 1'b1;
            ce1_q  <= 1'b1;
            ce2_q  <= 1'b0;
            ce3_q  <= 1'b1;
            gw_q   <= 1'b1;
            we_q   <= 1'b1;
            bw_q   <= 2'h3;
        end else begin
            addr_q <= address_inputs;
            din_q  <= data_lanes_in;
            // write data must pair with the controls taken at the same edge
            din_qq <= din_q;
            controller_addr_strobe_q <= controller_addr_strobe_n;
            processor_addr_strobe_q <= processor_addr_strobe_n;
            adv_q  <= burst_advance_n;
            ce1_q  <= chip_enable_main_n;
            ce2_q  <= depth_enable_high;
            ce3_q  <= depth_enable_low_n;
            gw_q   <= global_write_n;
            we_q   <= write_enable_n;
            bw_q   <= byte_write_lanes_n;
        end
    end

    pbs_burst_if bif ();

    pbs_burst_cnt u_cnt (
        .clk     (clk),
        .reset_n (reset_n),
        .bus     (bif.cnt)
    );

    logic       proc_start;
    logic       ctrl_start;
    logic       chip_sel;
    logic [1:0] lanes;
    logic       any_write;
    logic [ADDR_W-1:0] cur_addr;

    always_comb begin
        chip_sel   = !ce1_q && ce2_q && !ce3_q;
        proc_start = !processor_addr_strobe_q && !ce1_q;
        ctrl_start = !controller_addr_strobe_q && !proc_start;
        // global write overrides; write enable gates lanes individually
        lanes      = !gw_q ? 2'h3 : (!we_q ? ~bw_q : 2'h0);
        any_write  = lanes != 2'h0;
    end

    assign bif.load       = proc_start || ctrl_start;
    assign bif.load_low   = addr_q[BURST_W-1:0];
    assign bif.step       = !adv_q && controller_addr_strobe_q && !proc_start
                            && (st.cycle != PBS_IDLE);
    assign bif.interleave = burst_order_strap;
    assign cur_addr       = {st.addr[ADDR_W-1:BURST_W], bif.low_addr};

    // array port: self-timed write the edge after the cycle is set up
    always_ff @(posedge clk) begin
        if (st.cycle == PBS_WRITE && st.lane_we[0]) begin
            mem[cur_addr][LANE_W-1:0] <= din_qq[LANE_W-1:0];
        end
        if (st.cycle == PBS_WRITE && st.lane_we[1]) begin
            mem[cur_addr][DATA_W-1:LANE_W] <= din_qq[DATA_W-1:LANE_W];
        end
        array_word <= mem[cur_addr];
    end

    always_comb begin
        next_st           = st;
        next_st.read_pend = 1'b0;
        if (bif.load) begin
            next_st.addr = addr_q;
            if (ctrl_start && !chip_sel) begin
                next_st.cycle = PBS_IDLE;
            end else if (!chip_sel) begin
                next_st.cycle = PBS_IDLE;
            end else begin
                // processor strobe cycles are reads; write follows in next cycle
                next_st.cycle = (ctrl_start && any_write) ? PBS_WRITE : PBS_READ;
            end
            next_st.lane_we = ctrl_start ? lanes : 2'h0;
        end else if (st.cycle != PBS_IDLE && controller_addr_strobe_q && (!adv_q || any_write)) begin
            // continuation cycle: write decision taken from this edge
            next_st.cycle   = any_write ? PBS_WRITE : PBS_READ;
            next_st.lane_we = lanes;
        end else if (st.cycle != PBS_IDLE && controller_addr_strobe_q) begin
            // no advance and no write: the beat ends, address is kept for later
            next_st.cycle   = PBS_IDLE;
            next_st.lane_we = 2'h0;
        end
        next_st.read_pend = (st.cycle == PBS_READ);
        next_st.out_valid = st.read_pend;
        if (st.read_pend) begin
            next_st.dout = array_word;
        end
        next_st.read_data = array_word;
        next_st.oe        = !output_enable_n && st.read_pend;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{cycle: PBS_IDLE, addr: ADDR_RST, lane_we: 2'h0, read_pend: 1'b0,
                    read_data: DATA_RST, out_valid: 1'b0, dout: DATA_RST, oe: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // oe is async in the part; registered here, so it lags output_enable_n by one cycle
    assign data_lanes_out = st.dout;
    assign data_lanes_oe  = st.oe;

    a_deselect_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (!controller_addr_strobe_q && processor_addr_strobe_q && ce1_q) |=> st.cycle == PBS_IDLE)
        else $error("no deselect on controller strobe");
    a_proc_blocked: assert property (@(posedge clk) disable iff (!reset_n)
        (!processor_addr_strobe_q && controller_addr_strobe_q && ce1_q && st.cycle == PBS_IDLE) |=> st.cycle == PBS_IDLE)
        else $error("processor strobe not blocked");
    a_global_lanes: assert property (@(posedge clk) disable iff (!reset_n)
        (!controller_addr_strobe_q && processor_addr_strobe_q && chip_sel && !gw_q) |=> st.lane_we == 2'h3)
        else $error("global write missed a lane");
    a_byte_lanes: assert property (@(posedge clk) disable iff (!reset_n)
        (!controller_addr_strobe_q && processor_addr_strobe_q && chip_sel && gw_q && !we_q) |=> st.lane_we == ~$past(bw_q))
        else $error("byte lanes wrong");
    a_read_pipe: assert property (@(posedge clk) disable iff (!reset_n)
        st.cycle == PBS_READ |=> ##1 st.out_valid)
        else $error("read pipeline latency wrong");
    a_oe_float: assert property (@(posedge clk) disable iff (!reset_n)
        $past(output_enable_n) |-> !data_lanes_oe)
        else $error("driving while disabled");
    a_depth_gate: assert property (@(posedge clk) disable iff (!reset_n)
        (bif.load && (!ce2_q || ce3_q)) |=> st.cycle == PBS_IDLE)
        else $error("depth enable ignored");
    a_hold_addr: assert property (@(posedge clk) disable iff (!reset_n)
        (adv_q && controller_addr_strobe_q && processor_addr_strobe_q) |=> $stable(u_cnt.st))
        else $error("address moved without advance");
endmodule : pbs_sram

//--- pbs_host_model.sv
// processor side model: drives the sram pins, mirrors the array, predicts read data
`timescale 1ns/100ps
module pbs_host_model
    import pbs_pkg::*;
(
    // clock
    input  wire logic          clk,
    // address and control toward the sram
    output logic [ADDR_W-1:0]  address_inputs,
    output logic               controller_addr_strobe_n,
    output logic               processor_addr_strobe_n,
    output logic               burst_advance_n,
    output logic               global_write_n,
    output logic               write_enable_n,
    output logic [1:0]         byte_write_lanes_n,
    // static enables
    output logic               chip_enable_main_n,
    output logic               depth_enable_high,
    output logic               depth_enable_low_n,
    output logic               burst_order_strap,
    output logic               output_enable_n,
    // write data
    output logic [DATA_W-1:0]  data_lanes_in
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] exp_q [$];
    logic [DATA_W-1:0] last_wr;

    // a released bus shows the inverse of the last value, never a stale copy
    task automatic idle_pins();
        {controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n} = 3'h7;
        {global_write_n, write_enable_n, byte_write_lanes_n} = 4'hf;
        data_lanes_in = ~last_wr;
    endtask : idle_pins

    // strap moves only while the pipe is empty, never inside a burst
    task automatic set_static(input logic [4:0] e);
        repeat (4) @(negedge clk);
        {burst_order_strap, chip_enable_main_n, depth_enable_high, depth_enable_low_n,
         output_enable_n} = e;
    endtask : set_static

    task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                              input logic [3:0] wr_n);
        @(negedge clk);
        address_inputs = a;
        data_lanes_in = d;
        last_wr = d;
        controller_addr_strobe_n = 1'b0;
        {global_write_n, write_enable_n, byte_write_lanes_n} = wr_n;
        if (wr_n[3] && (wr_n[2] || wr_n[1:0] == 2'h3)) exp_q.push_back(mem[a]);
        if (!wr_n[3] || (!wr_n[2] && !wr_n[0])) mem[a][8:0] = d[8:0];
        if (!wr_n[3] || (!wr_n[2] && !wr_n[1])) mem[a][17:9] = d[17:9];
        @(negedge clk);
        idle_pins();
    endtask : write_word

    task automatic read_burst(input logic [ADDR_W-1:0] a, input logic proc, input int beats,
                              input logic hit);
        logic [1:0] low;
        @(negedge clk);
        address_inputs = a;
        if (proc) processor_addr_strobe_n = 1'b0;
        else controller_addr_strobe_n = 1'b0;
        for (int k = 0; k < beats; k++) begin
            if (k > 0) begin
                @(negedge clk);
                {controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n} = 3'h6;
            end
            low = burst_order_strap ? (a[1:0] ^ k[1:0]) : (a[1:0] + k[1:0]);
            if (hit) exp_q.push_back(mem[{a[ADDR_W-1:2], low}]);
        end
        @(negedge clk);
        idle_pins();
    endtask : read_burst

    initial begin
        last_wr = 18'h00000;
        address_inputs = 18'h00000;
        {burst_order_strap, chip_enable_main_n, depth_enable_high, depth_enable_low_n,
         output_enable_n} = 5'h04;
        idle_pins();
    end
endmodule : pbs_host_model

//--- pipelined_burst_sync_sram_bench.sv
// self-checking testbench for the pipelined burst sram
`timescale 1ns/100ps
module pipelined_burst_sync_sram_bench
    import pbs_pkg::*;
;
    logic              clk = 1'b0;
    logic              reset_n;
    logic [ADDR_W-1:0] address_inputs;
    logic              controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n;
    logic              chip_enable_main_n, depth_enable_high, depth_enable_low_n;
    logic              global_write_n, write_enable_n, burst_order_strap, output_enable_n;
    logic [1:0]        byte_write_lanes_n;
    logic [DATA_W-1:0] data_lanes_in, data_lanes_out, exp_word;
    logic              data_lanes_oe;
    int                num_errors = 0;
    int                n_compared = 0;
    integer            seed;

    always #2.5 clk = ~clk;

    pbs_sram pbs_sram_i (.clk, .reset_n, .address_inputs, .controller_addr_strobe_n,
        .processor_addr_strobe_n, .burst_advance_n, .chip_enable_main_n, .depth_enable_high,
        .depth_enable_low_n, .global_write_n, .write_enable_n, .byte_write_lanes_n,
        .burst_order_strap, .output_enable_n, .data_lanes_in, .data_lanes_out, .data_lanes_oe);

    pbs_host_model pbs_host_model_i (.clk, .address_inputs, .controller_addr_strobe_n,
        .processor_addr_strobe_n, .burst_advance_n, .global_write_n, .write_enable_n,
        .byte_write_lanes_n, .chip_enable_main_n, .depth_enable_high, .depth_enable_low_n,
        .burst_order_strap, .output_enable_n, .data_lanes_in);

    task automatic check(input string what, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // an unexpected beat meets an empty queue and fails against all-x
    always @(negedge clk) begin
        if (data_lanes_oe === 1'b1) begin
            exp_word = {DATA_W{1'bx}};
            if (pbs_host_model_i.exp_q.size() > 0) exp_word = pbs_host_model_i.exp_q.pop_front();
            check("read data", data_lanes_out, exp_word);
        end
    end

    initial begin
        #20000;
        num_errors++;
        final_report();
    end

    initial begin
        logic [ADDR_W-1:0] base;
        logic [3:0]        codes [5];
        logic [3:0]        refuse [6];
        codes = '{4'h7, 4'ha, 4'h9, 4'h8, 4'hc};
        refuse = '{4'hc, 4'hc, 4'h0, 4'h5, 4'h6, 4'h4};
        seed = 32'h0143;
        reset_n = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        for (int m = 0; m < 2; m++) begin
            pbs_host_model_i.set_static({m[0], 4'h4});
            base = ADDR_W'($random(seed)) & 18'h3fffc;
            for (int k = 0; k < 4; k++) begin
                pbs_host_model_i.write_word(base + 18'(k), 18'($random(seed)), 4'h7);
            end
            pbs_host_model_i.read_burst(base | 18'(m + 1), 1'b0, 4, 1'b1);
            pbs_host_model_i.read_burst(base | 18'(m + 2), 1'b1, 2, 1'b1);
        end
        // lane writes: global alone, lane a, lane b, both lanes, lanes without enable
        for (int i = 0; i < 5; i++) begin
            pbs_host_model_i.write_word(base, 18'($random(seed)), codes[i]);
            pbs_host_model_i.read_burst(base, 1'b1, 1, 1'b1);
        end
        for (int i = 0; i < 6; i++) begin
            pbs_host_model_i.set_static({1'b0, refuse[i]});
            pbs_host_model_i.read_burst(base, i == 0, 1, refuse[i] == 4'h4);
        end
        repeat (6) @(negedge clk);
        check("pending reads", 18'(pbs_host_model_i.exp_q.size()), 18'h00000);
        final_report();
    end
endmodule : pipelined_burst_sync_sram_bench
